// [rtl/rbbc_consts.vh]
// Constants for the reset and boot bank control block.
// Assumes a 100 MHz ref_clk standing in for the oscillator clock.
`ifndef RBBC_CONSTS_VH
`define RBBC_CONSTS_VH

// ----------------------------------------------------------------------
// Register map (byte addresses, word aligned)
// ----------------------------------------------------------------------
`define RBBC_ADDR_CTRL        4'h0
`define RBBC_ADDR_STATUS      4'h4
`define RBBC_ADDR_FLASHCFG    4'h8
`define RBBC_ADDR_IRQEN       4'hc

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RBBC_CTRL_LATCHOFF    0
`define RBBC_CTRL_SIXCLK      1
`define RBBC_CTRL_EMUFLAG     2
`define RBBC_CTRL_BOOTDONE    3
`define RBBC_CTRL_WDTKEEP     4
`define RBBC_CTRL_XDATA       5
`define RBBC_STAT_POWERUP     0
`define RBBC_STAT_HOSTMODE    1
`define RBBC_STAT_EXTFETCH    2
`define RBBC_STAT_BROWNOUT    3
`define RBBC_STAT_EMUMODE     4
`define RBBC_FCF_BANKSEL      0
`define RBBC_FCF_SOFTREQ      1
`define RBBC_IEA_BOIRQEN      3

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define RBBC_OSC_PER_MC_STD   4'd12
`define RBBC_OSC_PER_MC_SIX   4'd6
`define RBBC_RESET_MC         8'd2
`define RBBC_HOST_MC          8'd10
`define RBBC_BROWNOUT_OSC     3'd4
`define RBBC_AUTOBAUD_MS      400
`define RBBC_CLK_KHZ          100000

`endif

// [rtl/rbbc_sync.v]
// Two-flip-flop synchroniser for one asynchronous level.
// Assumes ref_clk domain; clkEn freezes it like the rest of the block.
`default_nettype none

module rbbc_sync (
    // Clock and control
    input  wire ref_clk,
    input  wire srst,
    input  wire clkEn,
    // Data
    input  wire asyncIn,
    output wire syncOut
);
    reg stage1_reg;
    reg stage2_reg;

    always @(posedge ref_clk) begin
        if (srst) begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
        end else if (clkEn) begin
            stage1_reg <= asyncIn;
            stage2_reg <= stage1_reg;
        end
    end

    assign syncOut = stage2_reg;
endmodule

`default_nettype wire

// [rtl/rbbc_top.v]
// Reset sequencing, boot bank control and address latch strobe generation.
// Assumes pins are asynchronous to ref_clk; registers on Avalon-MM, 4-bit byte address.
//
// Design decisions made here: register access over Avalon-MM and the register offsets.
`default_nettype none
`include "rbbc_consts.vh"

module rbbc_top #(
    parameter AUTOBAUD_CYCLES = `RBBC_AUTOBAUD_MS * `RBBC_CLK_KHZ
) (
    // Clock, reset, enable
    input  wire        ref_clk,
    input  wire        srst,
    input  wire        clkEn,
    // Avalon-MM slave
    input  wire [3:0]  avAddress,
    input  wire        avRead,
    input  wire        avWrite,
    input  wire [31:0] avWriteData,
    output reg  [31:0] avReadData,
    output reg         avWaitRequest,
    // Pins and reset sources
    input  wire        resetPin,
    input  wire        progStoreStrobeIn,
    input  wire        extAccessSelect,
    input  wire        brownoutLow,
    input  wire        watchdogReset,
    input  wire        autobaudOk,
    // Core-facing inputs and outputs
    input  wire [15:0] fetchAddr,
    output reg         cpuReset,
    output reg         pcClear,
    output reg         brownoutIrq,
    output reg         bootBlockSel,
    output reg         extFetch,
    output reg         hostMode,
    output reg         addrLatchStrobe
);
    // ------------------------------------------------------------------
    // Synchronised pins
    // ------------------------------------------------------------------
    wire rstSync;
    wire psenSync;
    wire eaSync;
    wire boSync;

    rbbc_sync uRst (.ref_clk(ref_clk), .srst(srst), .clkEn(clkEn),
                    .asyncIn(resetPin), .syncOut(rstSync));
    rbbc_sync uPsen (.ref_clk(ref_clk), .srst(srst), .clkEn(clkEn),
                     .asyncIn(progStoreStrobeIn), .syncOut(psenSync));
    rbbc_sync uEa (.ref_clk(ref_clk), .srst(srst), .clkEn(clkEn),
                   .asyncIn(extAccessSelect), .syncOut(eaSync));
    rbbc_sync uBo (.ref_clk(ref_clk), .srst(srst), .clkEn(clkEn),
                   .asyncIn(brownoutLow), .syncOut(boSync));

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    reg        latchOff_reg;
    reg        sixClk_reg;
    reg        emuFlag_reg;
    reg        bootDone_reg;
    reg        wdtKeep_reg;
    reg        xdataAcc_reg;
    reg        powerUp_reg;
    reg        softReq_reg;
    reg        bankSel_reg;
    reg        boIrqEn_reg;
    reg        emuMode_reg;
    reg        porDone_reg;
    reg [3:0]  oscCnt_reg;
    reg        mcTick_reg;
    reg [7:0]  rstMc_reg;
    reg        psenPrev_reg;
    reg        hostArm_reg;
    reg [2:0]  boCnt_reg;
    reg        boActive_reg;
    reg [31:0] baudCnt_reg;
    reg [1:0]  aleCnt_reg;
    reg        skipPending_reg;
    reg        xdataPrev_reg;
    reg        boRstPrev_reg;

    wire [3:0] mcLen = sixClk_reg ? `RBBC_OSC_PER_MC_SIX : `RBBC_OSC_PER_MC_STD;
    wire       extRstHeld = rstMc_reg >= `RBBC_RESET_MC;
    // A write lands only at the edge where waitrequest is seen low. The master
    // holds its request until that edge, so landing it one edge earlier would
    // commit a write that the master does not yet count as complete.
    wire       busAcc = avWrite && !avWaitRequest;
    wire       wrCtrl = busAcc && avWrite && avAddress == `RBBC_ADDR_CTRL;
    wire       wrStat = busAcc && avWrite && avAddress == `RBBC_ADDR_STATUS;
    wire       wrFcf  = busAcc && avWrite && avAddress == `RBBC_ADDR_FLASHCFG;
    wire       wrIea  = busAcc && avWrite && avAddress == `RBBC_ADDR_IRQEN;
    wire       softEdge = wrFcf && !softReq_reg
                          && avWriteData[`RBBC_FCF_SOFTREQ];
    wire       ieaClearInBo = wrIea && boIrqEn_reg && boActive_reg
                              && !avWriteData[`RBBC_IEA_BOIRQEN];
    // The brownout condition is a level that can last many cycles, while a
    // reset is an event. Only the first cycle of the level resets, so one dip
    // gives one pcClear pulse and does not hold the core in a reset loop.
    wire       boResetLvl = boActive_reg && (!boIrqEn_reg || ieaClearInBo);
    wire       boReset = boResetLvl && !boRstPrev_reg;
    wire       baudTimeout = !bootDone_reg && !emuMode_reg
                             && baudCnt_reg >= AUTOBAUD_CYCLES - 1;
    wire       bootSoft = baudTimeout && !autobaudOk && !emuFlag_reg;
    wire       anySoft = softEdge || bootSoft;

    // ------------------------------------------------------------------
    // Machine cycle timing
    // ------------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (srst) begin
            oscCnt_reg <= 4'h0;
            mcTick_reg <= 1'b0;
        end else if (clkEn) begin
            mcTick_reg <= oscCnt_reg == mcLen - 4'h1;
            oscCnt_reg <= (oscCnt_reg >= mcLen - 4'h1) ? 4'h0 : oscCnt_reg + 4'h1;
        end
    end

    // ------------------------------------------------------------------
    // Reset pin, host mode entry, brownout filter
    // ------------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (srst) begin
            rstMc_reg    <= 8'h00;
            psenPrev_reg <= 1'b1;
            hostArm_reg  <= 1'b0;
            hostMode     <= 1'b0;
            boCnt_reg    <= 3'h0;
            boActive_reg <= 1'b0;
        end else if (clkEn) begin
            psenPrev_reg <= psenSync;
            if (!rstSync) begin
                rstMc_reg   <= 8'h00;
                hostArm_reg <= 1'b0;
            end else if (mcTick_reg && rstMc_reg != 8'hff) begin
                rstMc_reg <= rstMc_reg + 8'h01;
            end
            if (rstSync && psenPrev_reg && !psenSync)
                hostArm_reg <= 1'b1;
            // Decision is taken when reset is released.
            if (rstMc_reg != 8'h00 && !rstSync)
                hostMode <= hostArm_reg && rstMc_reg > `RBBC_HOST_MC;
            if (!boSync) begin
                boCnt_reg    <= 3'h0;
                boActive_reg <= 1'b0;
            end else if (boCnt_reg < `RBBC_BROWNOUT_OSC - 3'h1) begin
                boCnt_reg <= boCnt_reg + 3'h1;
            end else begin
                boActive_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Brownout reset edge
    // ------------------------------------------------------------------
    // Remembers whether the brownout reset level was already present, so
    // that a long dip is reported once. Clearing the interrupt enable during
    // a dip raises the level from low, which gives the one reset it needs.
    always @(posedge ref_clk) begin
        if (srst) begin
            boRstPrev_reg <= 1'b0;
        end else if (clkEn) begin
            boRstPrev_reg <= boResetLvl;
        end
    end

    // ------------------------------------------------------------------
    // Reset sources and bank bits
    // ------------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (srst) begin
            powerUp_reg  <= 1'b1;
            softReq_reg  <= 1'b0;
            bankSel_reg  <= 1'b0;
            porDone_reg  <= 1'b0;
            cpuReset     <= 1'b1;
            pcClear      <= 1'b0;
            brownoutIrq  <= 1'b0;
            baudCnt_reg  <= 32'h0;
            emuMode_reg  <= 1'b0;
            bootDone_reg <= 1'b0;
        end else if (clkEn) begin
            porDone_reg <= 1'b1;
            pcClear     <= 1'b0;
            cpuReset    <= extRstHeld || !porDone_reg;
            brownoutIrq <= boActive_reg && boIrqEn_reg;
            if (wrStat && avWriteData[`RBBC_STAT_POWERUP])
                powerUp_reg <= 1'b0;
            if (extRstHeld) begin
                softReq_reg  <= 1'b0;
                bankSel_reg  <= 1'b0;
                baudCnt_reg  <= 32'h0;
                emuMode_reg  <= 1'b0;
                bootDone_reg <= 1'b0;
            end else if (anySoft) begin
                softReq_reg  <= 1'b1;
                bankSel_reg  <= 1'b0;
                pcClear      <= 1'b1;
                bootDone_reg <= 1'b1;
            end else if (boReset || watchdogReset) begin
                bankSel_reg <= 1'b0;
                pcClear     <= 1'b1;
            end else begin
                if (wrFcf)
                    bankSel_reg <= avWriteData[`RBBC_FCF_BANKSEL];
                if (!bootDone_reg && !emuMode_reg) begin
                    baudCnt_reg <= baudCnt_reg + 32'h1;
                    if (autobaudOk)
                        bootDone_reg <= 1'b1;
                    else if (baudTimeout)
                        emuMode_reg <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Bank decode and fetch source
    // ------------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (srst) begin
            bootBlockSel <= 1'b1;
            extFetch     <= 1'b0;
        end else if (clkEn) begin
            bootBlockSel <= !softReq_reg && fetchAddr[15:13] == 3'h0;
            extFetch     <= !eaSync;
        end
    end

    // ------------------------------------------------------------------
    // Control registers; a soft reset restores all but the six-clock, emulation and watchdog bits
    // ------------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (srst) begin
            latchOff_reg <= 1'b0;
            sixClk_reg   <= 1'b0;
            emuFlag_reg  <= 1'b0;
            wdtKeep_reg  <= 1'b0;
            xdataAcc_reg <= 1'b0;
            boIrqEn_reg  <= 1'b0;
        end else if (clkEn) begin
            if (anySoft || extRstHeld || boReset || watchdogReset) begin
                latchOff_reg <= 1'b0;
                xdataAcc_reg <= 1'b0;
                boIrqEn_reg  <= 1'b0;
                if (extRstHeld)
                    wdtKeep_reg <= 1'b0;
            end else begin
                if (wrCtrl) begin
                    latchOff_reg <= avWriteData[`RBBC_CTRL_LATCHOFF];
                    sixClk_reg   <= avWriteData[`RBBC_CTRL_SIXCLK];
                    emuFlag_reg  <= avWriteData[`RBBC_CTRL_EMUFLAG];
                    wdtKeep_reg  <= avWriteData[`RBBC_CTRL_WDTKEEP];
                    xdataAcc_reg <= avWriteData[`RBBC_CTRL_XDATA];
                end
                if (wrIea)
                    boIrqEn_reg <= avWriteData[`RBBC_IEA_BOIRQEN];
            end
        end
    end

    // ------------------------------------------------------------------
    // Address latch strobe: two pulses per machine cycle
    // ------------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (srst) begin
            aleCnt_reg      <= 2'h0;
            addrLatchStrobe <= 1'b0;
            skipPending_reg <= 1'b0;
            xdataPrev_reg   <= 1'b0;
        end else if (clkEn) begin
            xdataPrev_reg <= xdataAcc_reg;
            addrLatchStrobe <= 1'b0;
            if (xdataAcc_reg && !xdataPrev_reg)
                skipPending_reg <= 1'b1;
            if (oscCnt_reg == 4'h0 || oscCnt_reg == (mcLen >> 1)) begin
                if (skipPending_reg) begin
                    skipPending_reg <= 1'b0;
                end else if (!latchOff_reg && !cpuReset) begin
                    addrLatchStrobe <= 1'b1;
                end
            end
            aleCnt_reg <= aleCnt_reg + 2'h1;
        end
    end

    // ------------------------------------------------------------------
    // Avalon-MM slave: one wait cycle, then answer
    // ------------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (srst) begin
            avWaitRequest <= 1'b1;
            avReadData    <= 32'h0;
        end else if (clkEn) begin
            avWaitRequest <= !((avRead || avWrite) && avWaitRequest);
            if (avRead && avWaitRequest) begin
                case (avAddress)
                    `RBBC_ADDR_CTRL:
                        avReadData <= {26'h0, xdataAcc_reg, wdtKeep_reg, bootDone_reg,
                                       emuFlag_reg, sixClk_reg, latchOff_reg};
                    `RBBC_ADDR_STATUS:
                        avReadData <= {27'h0, emuMode_reg, boActive_reg, extFetch,
                                       hostMode, powerUp_reg};
                    `RBBC_ADDR_FLASHCFG:
                        avReadData <= {30'h0, softReq_reg, bankSel_reg};
                    `RBBC_ADDR_IRQEN:
                        avReadData <= {28'h0, boIrqEn_reg, 3'h0};
                    default:
                        avReadData <= 32'h0;
                endcase
            end
        end
    end
endmodule

`default_nettype wire

// [tb/rbbc_top_assertions.sv]
// Port-level checks for the reset and boot bank block.
// Assumes clkEn is held high, so no cycle is ever frozen.
`default_nettype none
module rbbc_top_checker (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        srst,
    // Bus
    input wire logic        avRead,
    input wire logic        avWrite,
    input wire logic        avWaitRequest,
    // Pins and outputs
    input wire logic        resetPin,
    input wire logic        brownoutLow,
    input wire logic        watchdogReset,
    input wire logic [15:0] fetchAddr,
    input wire logic        cpuReset,
    input wire logic        pcClear,
    input wire logic        brownoutIrq,
    input wire logic        bootBlockSel,
    input wire logic        addrLatchStrobe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] pinHighCnt;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    // Saturates, so a reset pin held for hundreds of cycles stays counted.
    always @(posedge ref_clk) begin
        if (srst || !resetPin) pinHighCnt <= 6'h0;
        else if (pinHighCnt != 6'h3f) pinHighCnt <= pinHighCnt + 6'h1;
    end
    bus_answer_a: assert property ((avRead || avWrite) && avWaitRequest |=> !avWaitRequest)
        else $error("bus request not answered in one cycle");
    bus_release_a: assert property (!avWaitRequest |=> avWaitRequest)
        else $error("waitrequest low for more than one cycle");
    reset_pin_hold_a: assert property (pinHighCnt >= 6'd30 |-> cpuReset)
        else $error("long reset pin did not reset");
    boot_map_pin_a: assert property (pinHighCnt >= 6'd40 && fetchAddr[15:13] == 3'h0 |-> bootBlockSel)
        else $error("pin reset did not map boot block");
    high_addr_user_a: assert property ((fetchAddr[15:13] != 3'h0) [*3] |-> !bootBlockSel)
        else $error("high address mapped to boot block");
    strobe_pulse_a: assert property (addrLatchStrobe |=> !addrLatchStrobe)
        else $error("latch strobe longer than one cycle");
    pcclear_pulse_a: assert property (pcClear |=> !pcClear)
        else $error("pcClear longer than one cycle");
    watchdog_clear_a: assert property (watchdogReset |-> ##[1:4] pcClear)
        else $error("watchdog reset did not clear pc");
    brownout_filter_a: assert property ($rose(brownoutIrq) |-> $past(brownoutLow, 3) && $past(brownoutLow, 6))
        else $error("brownout acted on a short dip");
endmodule
bind rbbc_top rbbc_top_checker rbbc_top_checker_inst (.ref_clk(ref_clk), .srst(srst),
    .avRead(avRead), .avWrite(avWrite), .avWaitRequest(avWaitRequest), .resetPin(resetPin),
    .brownoutLow(brownoutLow), .watchdogReset(watchdogReset), .fetchAddr(fetchAddr),
    .cpuReset(cpuReset), .pcClear(pcClear), .brownoutIrq(brownoutIrq),
    .bootBlockSel(bootBlockSel), .addrLatchStrobe(addrLatchStrobe));
`default_nettype wire

// [tb/rbbc_reset_host.sv]
// External reset circuit and programming host on the reset and strobe pins.
// Assumes hold_reset is called just after a rising edge of ref_clk.
`default_nettype none
module rbbc_reset_host (
    // Clock
    input  wire logic ref_clk,
    // Pins
    output var  logic resetPin,
    output var  logic progStoreStrobeIn
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        resetPin = 1'b0;
        progStoreStrobeIn = 1'b1;
    end
    // The strobe returns high a few cycles late so the fall is never masked by release.
    task automatic hold_reset(input int cycles, input bit strobeFall);
        resetPin <= 1'b1;
        repeat (cycles / 2) @(posedge ref_clk);
        if (strobeFall) progStoreStrobeIn <= 1'b0;
        repeat (cycles - cycles / 2) @(posedge ref_clk);
        resetPin <= 1'b0;
        repeat (4) @(posedge ref_clk);
        progStoreStrobeIn <= 1'b1;
    endtask
endmodule
`default_nettype wire

// [tb/rbbc_top_test.sv]
// Self-checking bench for the reset and boot bank block.
// Assumes the constants header is on the include path; clkEn stays high.
`default_nettype none
`include "rbbc_consts.vh"
module rbbc_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 1'b0;
    logic        srst = 1'b1;
    logic [3:0]  avAddress = 4'h0;
    logic        avRead = 1'b0;
    logic        avWrite = 1'b0;
    logic [31:0] avWriteData = 32'h0;
    logic [31:0] avReadData;
    logic        avWaitRequest;
    logic        resetPin;
    logic        progStoreStrobeIn;
    logic        extAccessSelect = 1'b1;
    logic        brownoutLow = 1'b0;
    logic        watchdogReset = 1'b0;
    logic        autobaudOk = 1'b1;
    logic [15:0] fetchAddr = 16'h0;
    logic        cpuReset;
    logic        pcClear;
    logic        brownoutIrq;
    logic        bootBlockSel;
    logic        extFetch;
    logic        hostMode;
    logic        addrLatchStrobe;
    logic [31:0] rd;
    int          num_errors = 0;
    int          cmp_count = 0;
    int          pulseCnt = 0;
    int          rstCnt = 0;
    int          rstBase = 0;
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (pcClear === 1'b1) pulseCnt <= pulseCnt + 1;
        if (cpuReset === 1'b1 && !srst) rstCnt <= rstCnt + 1;
    end
    rbbc_reset_host rbbc_reset_host_inst (.ref_clk(ref_clk), .resetPin(resetPin),
        .progStoreStrobeIn(progStoreStrobeIn));
    rbbc_top #(.AUTOBAUD_CYCLES(200)) rbbc_top_inst (.ref_clk(ref_clk), .srst(srst),
        .clkEn(1'b1), .avAddress(avAddress), .avRead(avRead), .avWrite(avWrite),
        .avWriteData(avWriteData), .avReadData(avReadData), .avWaitRequest(avWaitRequest),
        .resetPin(resetPin), .progStoreStrobeIn(progStoreStrobeIn),
        .extAccessSelect(extAccessSelect), .brownoutLow(brownoutLow),
        .watchdogReset(watchdogReset), .autobaudOk(autobaudOk), .fetchAddr(fetchAddr),
        .cpuReset(cpuReset), .pcClear(pcClear), .brownoutIrq(brownoutIrq),
        .bootBlockSel(bootBlockSel), .extFetch(extFetch), .hostMode(hostMode),
        .addrLatchStrobe(addrLatchStrobe));
    // --------
    // Tasks
    // --------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // One edge passes after release so a following access never re-raises in the same step.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avAddress <= a;
        avWriteData <= d;
        avWrite <= wr;
        avRead <= !wr;
        @(posedge ref_clk);
        while (avWaitRequest !== 1'b0 && n < 20) begin
            n++;
            @(posedge ref_clk);
        end
        if (n == 20) num_errors++;
        rd = avReadData;
        avWrite <= 1'b0;
        avRead <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rdchk(input string what, input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(what, exp, rd);
    endtask
    task automatic strobes(input string what, input int exp);
        int c;
        c = 0;
        repeat (60) begin
            @(posedge ref_clk);
            if (addrLatchStrobe === 1'b1) c++;
        end
        check(what, exp, c);
    endtask
    task automatic test_done;
        if (num_errors == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // --------
    // Sequence
    // --------
    initial begin
        cyc(10);
        srst <= 1'b0;
        cyc(4);
        check("bootSel", 32'h1, bootBlockSel);
        rdchk("fcf", `RBBC_ADDR_FLASHCFG, 32'h0);
        rdchk("status", `RBBC_ADDR_STATUS, 32'h1);
        bus(1'b1, `RBBC_ADDR_STATUS, 32'h1);
        rdchk("status", `RBBC_ADDR_STATUS, 32'h0);
        rdchk("unmapped", 4'h2, 32'h0);
        fetchAddr <= 16'h2000;
        cyc(3);
        check("bootSel", 32'h0, bootBlockSel);
        fetchAddr <= 16'h1fff;
        cyc(3);
        check("bootSel", 32'h1, bootBlockSel);
        fetchAddr <= 16'h0;
        strobes("strobeStd", 10);
        bus(1'b1, `RBBC_ADDR_CTRL, 32'h2);
        cyc(12);
        strobes("strobeSix", 20);
        bus(1'b1, `RBBC_ADDR_CTRL, 32'h1);
        cyc(12);
        strobes("strobeOff", 0);
        bus(1'b1, `RBBC_ADDR_CTRL, 32'h0);
        cyc(12);
        fork
            strobes("strobeXdata", 9);
            begin
                cyc(20);
                bus(1'b1, `RBBC_ADDR_CTRL, 32'h20);
            end
        join
        bus(1'b1, `RBBC_ADDR_CTRL, 32'h11);
        bus(1'b1, `RBBC_ADDR_FLASHCFG, 32'h2);
        cyc(5);
        check("softPulse", 32'h1, pulseCnt);
        rdchk("fcf", `RBBC_ADDR_FLASHCFG, 32'h2);
        check("bootSel", 32'h0, bootBlockSel);
        bus(1'b0, `RBBC_ADDR_CTRL, 32'h0);
        check("ctrlKeep", 32'h10, rd & 32'h17);
        bus(1'b1, `RBBC_ADDR_FLASHCFG, 32'h3);
        rdchk("fcf", `RBBC_ADDR_FLASHCFG, 32'h3);
        watchdogReset <= 1'b1;
        cyc(1);
        watchdogReset <= 1'b0;
        cyc(5);
        check("wdPulse", 32'h2, pulseCnt);
        rdchk("fcf", `RBBC_ADDR_FLASHCFG, 32'h2);
        bus(1'b1, `RBBC_ADDR_FLASHCFG, 32'h3);
        brownoutLow <= 1'b1;
        cyc(3);
        brownoutLow <= 1'b0;
        cyc(8);
        check("boGlitch", 32'h2, pulseCnt);
        brownoutLow <= 1'b1;
        cyc(12);
        brownoutLow <= 1'b0;
        cyc(4);
        check("boPulse", 32'h3, pulseCnt);
        rdchk("fcf", `RBBC_ADDR_FLASHCFG, 32'h2);
        bus(1'b1, `RBBC_ADDR_IRQEN, 32'h8);
        brownoutLow <= 1'b1;
        cyc(12);
        check("boIrq", 32'h1, brownoutIrq);
        check("boNoReset", 32'h3, pulseCnt);
        bus(1'b1, `RBBC_ADDR_IRQEN, 32'h0);
        cyc(4);
        check("boClear", 32'h4, pulseCnt);
        brownoutLow <= 1'b0;
        extAccessSelect <= 1'b0;
        rstBase = rstCnt;
        rbbc_reset_host_inst.hold_reset(10, 1'b0);
        cyc(6);
        check("shortPin", 32'h0, rstCnt - rstBase);
        rbbc_reset_host_inst.hold_reset(40, 1'b0);
        cyc(6);
        check("longPin", 32'h1, rstCnt != rstBase);
        check("extFetch", 32'h1, extFetch);
        check("normal", 32'h0, hostMode);
        rdchk("fcf", `RBBC_ADDR_FLASHCFG, 32'h0);
        extAccessSelect <= 1'b1;
        rbbc_reset_host_inst.hold_reset(150, 1'b1);
        cyc(6);
        check("hostMode", 32'h1, hostMode);
        check("intFetch", 32'h0, extFetch);
        autobaudOk <= 1'b0;
        rbbc_reset_host_inst.hold_reset(40, 1'b0);
        cyc(400);
        rdchk("fcfBaud", `RBBC_ADDR_FLASHCFG, 32'h2);
        bus(1'b1, `RBBC_ADDR_CTRL, 32'h4);
        rbbc_reset_host_inst.hold_reset(40, 1'b0);
        cyc(400);
        rdchk("statusEmu", `RBBC_ADDR_STATUS, 32'h10);
        rdchk("fcfEmu", `RBBC_ADDR_FLASHCFG, 32'h0);
        test_done();
    end
    initial begin
        cyc(10000);
        num_errors++;
        test_done();
    end
endmodule
`default_nettype wire
